// [hdl/pll_phase_step_and_output_pll_config.v]
// APB register bank for loop one phase step, slew limit and output loop settings
//
// Design decision made here: the APB slave port.
`include "pll_cfg_regs.vh"
`timescale 1ns/1ns
module pll_phase_step_and_output_pll_config (
	// Clock and reset
	input  wire        i_core_clk,
	input  wire        i_rst,
	// APB slave
	input  wire        i_psel,
	input  wire        i_penable,
	input  wire        i_pwrite,
	input  wire [15:0] i_paddr,
	input  wire [31:0] i_pwdata,
	output reg  [31:0] o_prdata,
	output reg         o_pready,
	output reg         o_pslverr,
	// Digital loop one phase controls
	output reg  [29:0] o_fixed_phase_offset,
	output reg  [15:0] o_phase_step_size,
	output reg  [15:0] o_slew_rate_limit,
	output reg         o_slew_limit_enable,
	output reg         o_phase_adjust_strobe,
	// Output loop one settings
	output reg  [7:0]  o_pump_current,
	output reg  [7:0]  o_output_feedback_divider,
	output reg  [1:0]  o_second_pole_resistor,
	output reg  [2:0]  o_zero_resistor,
	output reg  [2:0]  o_first_pole_capacitor,
	output reg         o_zero_resistor_bypass,
	output reg         o_loop_update_strobe
);
	localparam ST_IDLE = 3'b001;
	localparam ST_READ = 3'b010;
	localparam ST_DONE = 3'b100;

	reg  [2:0]  state;
	reg  [2:0]  next_state;
	reg         phase_pending;
	reg         loop_pending;
	reg         status_read;
	reg         hit;
	reg  [3:0]  index;
	reg  [7:0]  wmask;
	wire [7:0]  bank_rd;
	wire [95:0] bank;
	wire [11:0] offs;
	wire        setup;
	wire        wr_go;
	wire        apply_wr;
	wire        phase_group;
	wire [7:0]  wbyte;

	assign offs  = i_paddr[13:2];
	assign setup = i_psel && !i_penable;
	assign wr_go = i_psel && i_penable && i_pwrite && state == ST_DONE;
	assign apply_wr = wr_go && offs == `OFFS_APPLY;
	assign wbyte = i_pwdata[7:0] & wmask;
	assign phase_group = (index < 4'd4) || (index >= 4'd7 && index <= 4'd10);

	// Byte address equals four times the printed offset
	always @* begin
		hit   = 1'b1;
		index = 4'd0;
		wmask = 8'hff;
		case (offs)
			`OFFS_FIXED_OFFSET_0:       index = 4'd0;
			`OFFS_FIXED_OFFSET_1:       index = 4'd1;
			`OFFS_FIXED_OFFSET_2:       index = 4'd2;
			`OFFS_FIXED_OFFSET_3: begin
				index = 4'd3;
				wmask = `FIXED_OFFSET_TOP_MASK;
			end
			`OFFS_PHASE_STEP_SIZE_LOW:  index = 4'd7;
			`OFFS_PHASE_STEP_SIZE_HIGH: index = 4'd8;
			`OFFS_SLEW_RATE_LIMIT_LOW:  index = 4'd9;
			`OFFS_SLEW_RATE_LIMIT_HIGH: index = 4'd10;
			`OFFS_PUMP_CURRENT:         index = 4'd4;
			`OFFS_FEEDBACK_DIVIDER:     index = 4'd5;
			`OFFS_FILTER_SELECT:        index = 4'd6;
			`OFFS_ZERO_BYPASS: begin
				index = 4'd11;
				wmask = `ZERO_BYPASS_MASK;
			end
			`OFFS_APPLY:                index = 4'd15;
			`OFFS_STATUS:               index = 4'd15;
			default:                    hit = 1'b0;
		endcase
	end

	// Reset values live in the bank by index: 4 pump, 5 divider, 6 filter
	// Index is the memory slot, so the reset table lines up
	wire [3:0] mem_index;
	assign mem_index = index;

	// Staged bytes; nothing reaches the loops until an apply
	shadow_bank u_bank (
		.i_core_clk (i_core_clk),
		.i_rst      (i_rst),
		.i_wr_en    (wr_go && hit && index != 4'd15),
		.i_wr_index (mem_index),
		.i_wr_data  (wbyte),
		.i_rd_index (mem_index),
		.o_rd_data  (bank_rd),
		.o_all      (bank)
	);

	// Setup, one wait cycle for the registered read, then ready
	always @* begin
		case (state)
			ST_IDLE: next_state = setup ? ST_READ : ST_IDLE;
			ST_READ: next_state = ST_DONE;
			ST_DONE: next_state = ST_IDLE;
			default: next_state = ST_IDLE;
		endcase
	end

	always @(posedge i_core_clk) begin
		if (i_rst) begin
			state       <= ST_IDLE;
			o_pready    <= 1'b0;
			o_pslverr   <= 1'b0;
			o_prdata    <= 32'h00000000;
			status_read <= 1'b0;
		end else begin
			state       <= next_state;
			o_pready    <= next_state == ST_DONE;
			o_pslverr   <= next_state == ST_DONE && !hit;
			status_read <= offs == `OFFS_STATUS;
			if (next_state == ST_DONE) begin
				if (!hit || i_pwrite)
					o_prdata <= 32'h00000000;
				else if (status_read)
					o_prdata <= {29'h0000000, loop_pending, phase_pending, o_slew_limit_enable};
				else if (index == 4'd15)
					o_prdata <= 32'h00000000;
				else
					o_prdata <= {24'h000000, bank_rd};
			end else begin
				o_prdata <= 32'h00000000;
			end
		end
	end

	// Pending flags: a new staged write wins over a simultaneous apply
	always @(posedge i_core_clk) begin
		if (i_rst) begin
			phase_pending <= 1'b0;
			loop_pending  <= 1'b0;
		end else begin
			if (wr_go && hit && index != 4'd15 && phase_group)
				phase_pending <= 1'b1;
			else if (apply_wr && i_pwdata[`APPLY_PHASE_BIT])
				phase_pending <= 1'b0;
			if (wr_go && hit && index != 4'd15 && !phase_group)
				loop_pending <= 1'b1;
			else if (apply_wr && i_pwdata[`APPLY_LOOP_BIT])
				loop_pending <= 1'b0;
		end
	end

	// Whole words move to the outputs at once on apply
	always @(posedge i_core_clk) begin
		if (i_rst) begin
			o_fixed_phase_offset      <= `RST_FIXED_OFFSET_WORD;
			o_phase_step_size         <= {`RST_PHASE_STEP_SIZE, `RST_PHASE_STEP_SIZE};
			o_slew_rate_limit         <= {`RST_SLEW_RATE_LIMIT, `RST_SLEW_RATE_LIMIT};
			o_slew_limit_enable       <= 1'b0;
			o_phase_adjust_strobe     <= 1'b0;
			o_pump_current            <= `RST_PUMP_CURRENT;
			o_output_feedback_divider <= `RST_FEEDBACK_DIVIDER;
			o_second_pole_resistor    <= 2'b00;
			o_zero_resistor           <= 3'b000;
			o_first_pole_capacitor    <= 3'b111;
			o_zero_resistor_bypass    <= 1'b0;
			o_loop_update_strobe      <= 1'b0;
		end else begin
			o_phase_adjust_strobe <= 1'b0;
			o_loop_update_strobe  <= 1'b0;
			if (apply_wr && i_pwdata[`APPLY_PHASE_BIT]) begin
				o_fixed_phase_offset  <= {bank[29:24], bank[23:16], bank[15:8], bank[7:0]};
				o_phase_step_size     <= {bank[71:64], bank[63:56]};
				o_slew_rate_limit     <= {bank[87:80], bank[79:72]};
				o_slew_limit_enable   <= {bank[87:80], bank[79:72]} != 16'h0000;
				// Every phase apply triggers an adjustment, whichever phase field was staged; it is slewed only when the staged slew limit is nonzero
				o_phase_adjust_strobe <= 1'b1;
			end
			if (apply_wr && i_pwdata[`APPLY_LOOP_BIT]) begin
				o_pump_current            <= bank[39:32];
				o_output_feedback_divider <= bank[47:40];
				o_second_pole_resistor    <= bank[55:54];
				o_zero_resistor           <= bank[53:51];
				o_first_pole_capacitor    <= bank[50:48];
				o_zero_resistor_bypass    <= bank[88 + `ZERO_BYPASS_BIT];
				o_loop_update_strobe      <= 1'b1;
			end
		end
	end
endmodule // pll_phase_step_and_output_pll_config

// [hdl/shadow_bank.v]
// Small register memory holding staged byte values, read data registered
`include "pll_cfg_regs.vh"
`timescale 1ns/1ns
module shadow_bank (
	// Clock and reset
	input  wire        i_core_clk,
	input  wire        i_rst,
	// Write port
	input  wire        i_wr_en,
	input  wire [3:0]  i_wr_index,
	input  wire [7:0]  i_wr_data,
	// Read port
	input  wire [3:0]  i_rd_index,
	output reg  [7:0]  o_rd_data,
	// Full contents, flattened
	output wire [95:0] o_all
);
	reg [7:0] entry [0:11];
	genvar g;

	generate
		for (g = 0; g < 12; g = g + 1) begin : gen_entry
			always @(posedge i_core_clk) begin
				if (i_rst) begin
					case (g)
						4:       entry[g] <= `RST_PUMP_CURRENT;
						5:       entry[g] <= `RST_FEEDBACK_DIVIDER;
						6:       entry[g] <= `RST_FILTER_SELECT;
						default: entry[g] <= 8'h00;
					endcase
				end else if (i_wr_en && i_wr_index == g) begin
					entry[g] <= i_wr_data;
				end
			end
			assign o_all[g*8 +: 8] = entry[g];
		end
	endgenerate

	always @(posedge i_core_clk) begin
		if (i_rst)
			o_rd_data <= 8'h00;
		else if (i_rd_index < 4'd12)
			o_rd_data <= entry[i_rd_index];
		else
			o_rd_data <= 8'h00;
	end
endmodule // shadow_bank

// [include/pll_cfg_regs.vh]
// Register offsets, field positions and reset values of the loop configuration bank
`ifndef PLL_CFG_REGS_VH
`define PLL_CFG_REGS_VH

`define OFFS_FIXED_OFFSET_0        12'h50e
`define OFFS_FIXED_OFFSET_1        12'h50f
`define OFFS_FIXED_OFFSET_2        12'h510
`define OFFS_FIXED_OFFSET_3        12'h511
`define OFFS_PHASE_STEP_SIZE_LOW   12'h512
`define OFFS_PHASE_STEP_SIZE_HIGH  12'h513
`define OFFS_SLEW_RATE_LIMIT_LOW   12'h514
`define OFFS_SLEW_RATE_LIMIT_HIGH  12'h515
`define OFFS_PUMP_CURRENT          12'h520
`define OFFS_FEEDBACK_DIVIDER      12'h521
`define OFFS_FILTER_SELECT         12'h522
`define OFFS_ZERO_BYPASS           12'h523
`define OFFS_APPLY                 12'h530
`define OFFS_STATUS                12'h531

`define RST_FIXED_OFFSET           8'h00
`define RST_FIXED_OFFSET_WORD      30'h00000000
`define RST_PHASE_STEP_SIZE        8'h00
`define RST_SLEW_RATE_LIMIT        8'h00
`define RST_PUMP_CURRENT           8'h81
`define RST_FEEDBACK_DIVIDER       8'h14
`define RST_FILTER_SELECT          8'h07
`define RST_ZERO_BYPASS            8'h00

`define FIXED_OFFSET_TOP_MASK      8'h3f
`define ZERO_BYPASS_MASK           8'h01
`define FILTER_POLE2_MSB           7
`define FILTER_POLE2_LSB           6
`define FILTER_ZERO_MSB            5
`define FILTER_ZERO_LSB            3
`define FILTER_POLE1_MSB           2
`define FILTER_POLE1_LSB           0
`define ZERO_BYPASS_BIT            0

`define APPLY_PHASE_BIT            0
`define APPLY_LOOP_BIT             1
`define STATUS_SLEW_ENABLED_BIT    0
`define STATUS_PHASE_PENDING_BIT   1
`define STATUS_LOOP_PENDING_BIT    2

`define BANK_ENTRIES               12
`define BANK_INDEX_WIDTH           4

`endif

// [testbench/pll_cfg_properties.sv]
// Port checks of the loop configuration bank
`timescale 1ns/1ns
module pll_cfg_properties (
	input wire        i_core_clk,
	input wire        i_rst,
	input wire        i_psel,
	input wire        i_penable,
	input wire        o_pready,
	input wire [29:0] o_fixed_phase_offset,
	input wire [15:0] o_phase_step_size,
	input wire [15:0] o_slew_rate_limit,
	input wire        o_slew_limit_enable,
	input wire        o_phase_adjust_strobe,
	input wire        o_zero_resistor_bypass,
	input wire        o_loop_update_strobe
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_rst);
	property p_ready_time; i_psel && !i_penable |-> ##2 o_pready; endproperty
	a_ready_time: assert property (p_ready_time) else $error("ready not two cycles after setup");
	property p_step_apply; $changed(o_phase_step_size) |-> o_phase_adjust_strobe; endproperty
	a_step_apply: assert property (p_step_apply) else $error("step size moved without apply");
	property p_reset_zero; $fell(i_rst) |-> o_phase_step_size == 0 && o_slew_rate_limit == 0 && !o_zero_resistor_bypass;
	endproperty
	a_reset_zero: assert property (p_reset_zero) else $error("phase fields not zero after reset");
	property p_slew_apply; $changed(o_slew_rate_limit) |-> o_phase_adjust_strobe; endproperty
	a_slew_apply: assert property (p_slew_apply) else $error("slew limit moved without apply");
	property p_slew_enable; o_slew_limit_enable == (o_slew_rate_limit != 16'h0); endproperty
	a_slew_enable: assert property (p_slew_enable) else $error("slew enable wrong");
	property p_fixed_apply; $changed(o_fixed_phase_offset) |-> o_phase_adjust_strobe; endproperty
	a_fixed_apply: assert property (p_fixed_apply) else $error("fixed offset moved without apply");
	property p_bypass_apply; $changed(o_zero_resistor_bypass) |-> o_loop_update_strobe; endproperty
	a_bypass_apply: assert property (p_bypass_apply) else $error("bypass moved without apply");
	property p_strobe_pulse; o_phase_adjust_strobe |=> !o_phase_adjust_strobe; endproperty
	a_strobe_pulse: assert property (p_strobe_pulse) else $error("phase strobe too long");
	c_phase: cover property (o_phase_adjust_strobe);
	c_loop: cover property (o_loop_update_strobe);
	c_slew: cover property (o_slew_limit_enable);
endmodule // pll_cfg_properties
bind pll_phase_step_and_output_pll_config pll_cfg_properties u_props (.i_core_clk(i_core_clk), .i_rst(i_rst),
	.i_psel(i_psel), .i_penable(i_penable), .o_pready(o_pready), .o_fixed_phase_offset(o_fixed_phase_offset),
	.o_phase_step_size(o_phase_step_size), .o_slew_rate_limit(o_slew_rate_limit),
	.o_slew_limit_enable(o_slew_limit_enable), .o_phase_adjust_strobe(o_phase_adjust_strobe),
	.o_zero_resistor_bypass(o_zero_resistor_bypass), .o_loop_update_strobe(o_loop_update_strobe));

// [testbench/tb.sv]
// Self-checking bench for the loop configuration bank
`timescale 1ns/1ns
module tb;
	reg         i_core_clk, i_rst, i_psel, i_penable, i_pwrite, err;
	reg  [15:0] i_paddr;
	reg  [31:0] i_pwdata, rd;
	wire [31:0] o_prdata;
	wire        o_pready, o_pslverr, o_slew_limit_enable, o_phase_adjust_strobe, o_zero_resistor_bypass, o_loop_update_strobe;
	wire [29:0] o_fixed_phase_offset;
	wire [15:0] o_phase_step_size, o_slew_rate_limit;
	wire [7:0]  o_pump_current, o_output_feedback_divider;
	wire [2:0]  o_zero_resistor, o_first_pole_capacitor;
	wire [1:0]  o_second_pole_resistor;
	integer     miscompares = 0, n_tests = 0, i;
	reg  [11:0] offs [0:7] = '{12'h512, 12'h513, 12'h514, 12'h515, 12'h520, 12'h521, 12'h522, 12'h523};
	reg  [7:0]  rstv [0:7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h81, 8'h14, 8'h07, 8'h00};
	pll_phase_step_and_output_pll_config dut (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_psel(i_psel),
		.i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
		.o_pready(o_pready), .o_pslverr(o_pslverr), .o_fixed_phase_offset(o_fixed_phase_offset),
		.o_phase_step_size(o_phase_step_size), .o_slew_rate_limit(o_slew_rate_limit),
		.o_slew_limit_enable(o_slew_limit_enable), .o_phase_adjust_strobe(o_phase_adjust_strobe),
		.o_pump_current(o_pump_current), .o_output_feedback_divider(o_output_feedback_divider),
		.o_second_pole_resistor(o_second_pole_resistor), .o_zero_resistor(o_zero_resistor),
		.o_first_pole_capacitor(o_first_pole_capacitor), .o_zero_resistor_bypass(o_zero_resistor_bypass),
		.o_loop_update_strobe(o_loop_update_strobe));
	initial begin
		i_core_clk = 1'b0;
		forever #25 i_core_clk = ~i_core_clk;
	end
	task chk(input [32:0] seen, input [32:0] exp);
		begin
			n_tests = n_tests + 1;
			if (seen !== exp) begin
				miscompares = miscompares + 1;
				$display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
			end
		end
	endtask
	task end_of_test;
		begin
			if (miscompares == 0 && n_tests > 0)
				$display("TB: PASS");
			else
				$display("TB: FAIL");
			$finish;
		end
	endtask
	// One APB transfer; returns half a cycle after the answer so apply effects are settled
	task apb(input wr, input [11:0] off, input [7:0] d);
		integer n;
		begin
			n = 0;
			@(posedge i_core_clk);
			i_psel <= 1'b1;
			i_penable <= 1'b0;
			i_pwrite <= wr;
			i_paddr <= {2'b00, off, 2'b00};
			i_pwdata <= {24'h0, d};
			@(posedge i_core_clk);
			i_penable <= 1'b1;
			do begin
				@(posedge i_core_clk);
				n = n + 1;
			end while (o_pready !== 1'b1 && n < 20);
			if (o_pready !== 1'b1) begin
				miscompares = miscompares + 1;
				end_of_test;
			end
			rd = o_prdata;
			err = o_pslverr;
			i_psel <= 1'b0;
			i_penable <= 1'b0;
			@(negedge i_core_clk);
		end
	endtask
	initial begin
		i_rst = 1'b1;
		i_psel = 1'b0;
		i_penable = 1'b0;
		i_pwrite = 1'b0;
		i_paddr = 16'h0;
		i_pwdata = 32'h0;
		repeat (6) @(posedge i_core_clk);
		i_rst <= 1'b0;
		for (i = 0; i < 8; i = i + 1) begin
			apb(1'b0, offs[i], 8'h00);
			chk(rd, rstv[i]);
		end
		chk({o_slew_limit_enable, o_slew_rate_limit}, 0);
		apb(1'b1, 12'h512, 8'h34);
		apb(1'b1, 12'h513, 8'h12);
		apb(1'b1, 12'h514, 8'h36);
		apb(1'b1, 12'h515, 8'h01);
		for (i = 0; i < 4; i = i + 1)
			apb(1'b1, 12'h50e + i, 8'hff);
		chk(o_phase_step_size, 0);
		apb(1'b0, 12'h511, 8'h00);
		chk(rd, 32'h3f);
		apb(1'b1, 12'h530, 8'h01);
		chk(o_phase_adjust_strobe, 1);
		chk(o_phase_step_size, 16'h1234);
		chk({o_slew_limit_enable, o_slew_rate_limit}, 17'h10136);
		chk(o_fixed_phase_offset, 30'h3fffffff);
		apb(1'b1, 12'h514, 8'h00);
		apb(1'b1, 12'h515, 8'h00);
		apb(1'b1, 12'h530, 8'h01);
		chk({o_slew_limit_enable, o_slew_rate_limit}, 0);
		apb(1'b1, 12'h522, 8'ha5);
		apb(1'b1, 12'h523, 8'hff);
		apb(1'b0, 12'h523, 8'h00);
		chk(rd, 32'h1);
		apb(1'b0, 12'h531, 8'h00);
		chk(rd, 32'h4);
		chk(o_zero_resistor_bypass, 0);
		apb(1'b1, 12'h530, 8'h02);
		chk({o_loop_update_strobe, o_zero_resistor_bypass, o_second_pole_resistor, o_zero_resistor,
			o_first_pole_capacitor}, 10'h3a5);
		chk({o_pump_current, o_output_feedback_divider}, 16'h8114);
		apb(1'b1, 12'h600, 8'h55);
		chk({err, rd}, 33'h100000000);
		end_of_test;
	end
endmodule // tb
